// ---- rtl/rmp_pkg.sv ----
// constants for the remappable output select and mapping lock block
`default_nettype none
package rmp_pkg;
    localparam int          RMP_NUM_PINS      = 30;
    localparam int          RMP_NUM_INSEL     = 20;
    localparam int          RMP_PINS_PER_GRP  = 8;
    localparam logic [7:0]  RMP_OUTSEL_BASE   = 8'h00;
    localparam logic [7:0]  RMP_INSEL_BASE    = 8'h40;
    localparam logic [7:0]  RMP_CONFIGURATION_CONTROL_REGISTER_ADDR   = 8'h60;
    localparam logic [7:0]  RMP_STATUS_ADDR   = 8'h61;
    localparam int          RMP_LOCK_BIT      = 13;
    localparam int          RMP_ONEWAY_BIT    = 29;
    localparam logic [3:0]  RMP_SEL_RESET     = 4'h0;
    localparam logic        RMP_LOCK_RESET    = 1'b0;
    localparam logic [3:0]  RMP_SEL_NONE      = 4'h0;
    localparam logic [3:0]  RMP_SEL_1         = 4'h1;
    localparam logic [3:0]  RMP_SEL_2         = 4'h2;
    localparam logic [3:0]  RMP_SEL_3         = 4'h3;
    localparam logic [3:0]  RMP_SEL_4         = 4'h4;
    localparam logic [3:0]  RMP_SEL_5         = 4'h5;
    localparam logic [3:0]  RMP_SEL_6         = 4'h6;
    localparam logic [3:0]  RMP_SEL_7         = 4'h7;
    // pins present only on the 44-pin variant (one bit per pin index)
    localparam logic [29:0] RMP_PIN_44ONLY    = 30'h38387070;
    // pins absent on variants with usb
    localparam logic [29:0] RMP_PIN_NOUSB     = 30'h02010400;
endpackage : rmp_pkg
`default_nettype wire

// ---- rtl/rmp_remap_output_select_lock.sv ----
// remappable pin output select, input select storage and mapping lock
`default_nettype none
module rmp_remap_output_select_lock
    import rmp_pkg::*;
#(
    parameter bit PIN44 = 1'b1,
    parameter bit USB   = 1'b1
) (
    input  wire logic        i_sys_clk,            // system clock
    input  wire logic        i_rst,                // synchronous reset, high
    input  wire logic [7:0]  i_addr,               // register word index
    input  wire logic [31:0] i_wdata,              // write data
    input  wire logic        i_wr,                 // write strobe
    input  wire logic        i_rd,                 // read strobe
    output logic      [31:0] o_rdata,              // read data, cycle after read
    input  wire logic        i_unlock_granted,     // unlock sequence done
    input  wire logic        i_single_session,     // configuration word three bit
    input  wire logic        i_uart1_transmit,     // peripheral output
    input  wire logic        i_uart2_request_to_send, // peripheral output
    input  wire logic        i_uart1_request_to_send, // peripheral output
    input  wire logic        i_uart2_transmit,     // peripheral output
    input  wire logic        i_spi1_slave_select,  // peripheral output
    input  wire logic        i_spi2_slave_select,  // peripheral output
    input  wire logic        i_usb_bus_power_enable, // peripheral output
    input  wire logic        i_compare_output_1,   // peripheral output
    input  wire logic        i_compare_output_2,   // peripheral output
    input  wire logic        i_compare_output_3,   // peripheral output
    input  wire logic        i_compare_output_4,   // peripheral output
    input  wire logic        i_compare_output_5,   // peripheral output
    input  wire logic        i_comparator_1_output, // peripheral output
    input  wire logic        i_comparator_2_output, // peripheral output
    input  wire logic        i_comparator_3_output, // peripheral output
    input  wire logic        i_spi1_data_out,      // peripheral output
    input  wire logic        i_spi2_data_out,      // peripheral output
    input  wire logic        i_reference_clock_output, // peripheral output
    input  wire logic [29:0] i_gpio_out,           // other digital function level
    input  wire logic [29:0] i_gpio_oe,            // other digital function enable
    input  wire logic [29:0] i_analog_sel,         // pin assigned to analog
    output logic      [29:0] o_pin_out,            // pin driver level
    output logic      [29:0] o_pin_oe,             // pin driver enable
    output logic      [29:0] o_pin_mapped,         // remapped output owns the pin
    output logic             o_mapping_lock,       // lock state
    output logic      [79:0] o_input_select        // 20 input selects, 4 bits each
);

    // ------------------------------------------------------------
    // pin presence
    // ------------------------------------------------------------
    function automatic logic pin_present(input int idx);
        logic p;
        p = 1'b1;
        if (!PIN44 && RMP_PIN_44ONLY[idx])
            p = 1'b0;
        if (USB && RMP_PIN_NOUSB[idx])
            p = 1'b0;
        return p;
    endfunction : pin_present

    logic [3:0]  outsel_r [RMP_NUM_PINS];
    logic [3:0]  insel_r  [RMP_NUM_INSEL];
    logic        lock_r;
    logic        oneway_r;
    logic        wr_allow;

    assign wr_allow = i_wr && !lock_r;

    // ------------------------------------------------------------
    // single-session strap, caught on every clock, set to one during reset
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst)
            oneway_r <= 1'b1;
        else
            oneway_r <= i_single_session;
    end

    // ------------------------------------------------------------
    // mapping lock
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            lock_r <= RMP_LOCK_RESET;
        end else if (i_wr && i_addr == RMP_CONFIGURATION_CONTROL_REGISTER_ADDR && i_unlock_granted) begin
            if (i_wdata[RMP_LOCK_BIT])
                lock_r <= 1'b1;
            else if (!(oneway_r && lock_r))
                lock_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // select registers
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < RMP_NUM_PINS; i++) begin
            if (i_rst)
                outsel_r[i] <= RMP_SEL_RESET;
            else if (wr_allow && i_addr == RMP_OUTSEL_BASE + 8'(i) && pin_present(i))
                outsel_r[i] <= i_wdata[3:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        for (int j = 0; j < RMP_NUM_INSEL; j++) begin
            if (i_rst)
                insel_r[j] <= RMP_SEL_RESET;
            else if (wr_allow && i_addr == RMP_INSEL_BASE + 8'(j))
                insel_r[j] <= i_wdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            o_rdata <= 32'h0;
        end else if (i_rd) begin
            o_rdata <= 32'h0;
            if (i_addr == RMP_CONFIGURATION_CONTROL_REGISTER_ADDR)
                o_rdata[RMP_LOCK_BIT] <= lock_r;
            else if (i_addr == RMP_STATUS_ADDR)
                o_rdata[RMP_ONEWAY_BIT] <= oneway_r;
            else if (i_addr >= RMP_INSEL_BASE && i_addr < RMP_INSEL_BASE + 8'(RMP_NUM_INSEL))
                o_rdata[3:0] <= insel_r[5'(i_addr - RMP_INSEL_BASE)];
            else if (i_addr < RMP_OUTSEL_BASE + 8'(RMP_NUM_PINS))
                o_rdata[3:0] <= outsel_r[5'(i_addr)];
        end else begin
            o_rdata <= 32'h0;
        end
    end

    // ------------------------------------------------------------
    // output routing per group
    // ------------------------------------------------------------
    function automatic logic [1:0] route(input int idx, input logic [3:0] sel);
        logic [1:0] r;                                                // {valid, level}
        r = 2'b00;
        case (idx / RMP_PINS_PER_GRP)
            0: begin
                case (sel)
                    RMP_SEL_1: r = {1'b1, i_uart1_transmit};
                    RMP_SEL_2: r = {1'b1, i_uart2_request_to_send};
                    RMP_SEL_3: r = {1'b1, i_spi1_slave_select};
                    RMP_SEL_4: r = {USB, i_usb_bus_power_enable};
                    RMP_SEL_5: r = {1'b1, i_compare_output_1};
                    RMP_SEL_7: r = {1'b1, i_comparator_2_output};
                    default:   r = 2'b00;
                endcase
            end
            1: begin
                case (sel)
                    RMP_SEL_3: r = {1'b1, i_spi1_data_out};
                    RMP_SEL_4: r = {1'b1, i_spi2_data_out};
                    RMP_SEL_5: r = {1'b1, i_compare_output_2};
                    RMP_SEL_7: r = {1'b1, i_comparator_3_output};
                    default:   r = 2'b00;
                endcase
            end
            2: begin
                case (sel)
                    RMP_SEL_3: r = {1'b1, i_spi1_data_out};
                    RMP_SEL_4: r = {1'b1, i_spi2_data_out};
                    RMP_SEL_5: r = {1'b1, i_compare_output_4};
                    RMP_SEL_6: r = {1'b1, i_compare_output_5};
                    RMP_SEL_7: r = {1'b1, i_reference_clock_output};
                    default:   r = 2'b00;
                endcase
            end
            default: begin
                case (sel)
                    RMP_SEL_1: r = {1'b1, i_uart1_request_to_send};
                    RMP_SEL_2: r = {1'b1, i_uart2_transmit};
                    RMP_SEL_4: r = {1'b1, i_spi2_slave_select};
                    RMP_SEL_5: r = {1'b1, i_compare_output_3};
                    RMP_SEL_7: r = {1'b1, i_comparator_1_output};
                    default:   r = 2'b00;
                endcase
            end
        endcase
        return r;
    endfunction : route

    // groups hold pins 0-6, 7-14, 15-21, 22-29; remap the index into 8-wide groups
    function automatic int grp_idx(input int i);
        if (i < 7)
            return i;
        else if (i < 15)
            return 8 + (i - 7);
        else if (i < 22)
            return 16 + (i - 15);
        else
            return 24 + (i - 22);
    endfunction : grp_idx

    always_ff @(posedge i_sys_clk) begin
        for (int i = 0; i < RMP_NUM_PINS; i++) begin
            logic [1:0] r;
            r = route(grp_idx(i), outsel_r[i]);
            if (i_rst || !pin_present(i)) begin
                o_pin_out[i]    <= 1'b0;
                o_pin_oe[i]     <= 1'b0;
                o_pin_mapped[i] <= 1'b0;
            end else if (i_analog_sel[i]) begin
                o_pin_out[i]    <= 1'b0;
                o_pin_oe[i]     <= 1'b0;
                o_pin_mapped[i] <= 1'b0;
            end else if (r[1]) begin
                o_pin_out[i]    <= r[0];
                o_pin_oe[i]     <= 1'b1;
                o_pin_mapped[i] <= 1'b1;
            end else begin
                o_pin_out[i]    <= i_gpio_out[i];
                o_pin_oe[i]     <= i_gpio_oe[i];
                o_pin_mapped[i] <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst)
            o_mapping_lock <= 1'b0;
        else
            o_mapping_lock <= lock_r;
    end

    always_ff @(posedge i_sys_clk) begin
        for (int j = 0; j < RMP_NUM_INSEL; j++) begin
            if (i_rst)
                o_input_select[j*4 +: 4] <= RMP_SEL_RESET;
            else
                o_input_select[j*4 +: 4] <= insel_r[j];
        end
    end

endmodule : rmp_remap_output_select_lock
`default_nettype wire

// ---- verif/rmp_periph_model.sv ----
// peripheral output levels feeding the remap block
`default_nettype none
module rmp_periph_model (
    input  wire logic [17:0] i_level, // wanted levels
    output logic      [17:0] o_level  // to the block
);
    timeunit 1ns;
    timeprecision 1ps;
    assign o_level = i_level;
endmodule : rmp_periph_model
`default_nettype wire

// ---- verif/rmp_remap_properties.sv ----
// port assertions for the remap and lock block
`default_nettype none
module rmp_remap_checker
    import rmp_pkg::*;
(
    input wire logic        i_sys_clk,
    input wire logic        i_rst,
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic        i_unlock_granted,
    input wire logic        i_single_session,
    input wire logic [29:0] i_analog_sel,
    input wire logic [29:0] o_pin_oe,
    input wire logic [29:0] o_pin_mapped,
    input wire logic        o_mapping_lock,
    input wire logic [79:0] o_input_select
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    wire cfg_wr = i_wr && i_addr == RMP_CONFIGURATION_CONTROL_REGISTER_ADDR && i_unlock_granted;
    property p_lock_set;
        cfg_wr && i_wdata[RMP_LOCK_BIT] |-> ##2 o_mapping_lock;
    endproperty
    a_lock_set: assert property (p_lock_set) else $error("lock not set");
    property p_lock_rise;
        $rose(o_mapping_lock) |-> $past(cfg_wr && i_wdata[RMP_LOCK_BIT], 2);
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock set without grant");
    property p_lock_fall;
        $fell(o_mapping_lock) |-> $past(cfg_wr && !i_wdata[RMP_LOCK_BIT], 2) && !$past(i_single_session, 3);
    endproperty
    a_lock_fall: assert property (p_lock_fall) else $error("lock cleared wrongly");
    property p_locked_hold;
        o_mapping_lock ##1 o_mapping_lock |=> $stable(o_input_select);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("select changed under lock");
    property p_rdata_idle;
        !$past(i_rd) |-> o_rdata == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
    property p_analog_wins;
        (o_pin_mapped & $past(i_analog_sel)) == 30'h0;
    endproperty
    a_analog_wins: assert property (p_analog_wins) else $error("mapped over analog");
    property p_mapped_oe;
        (o_pin_mapped & ~o_pin_oe) == 30'h0;
    endproperty
    a_mapped_oe: assert property (p_mapped_oe) else $error("mapped pin not driven");
    property p_reset_clear;
        $past(i_rst) |-> o_pin_mapped == 30'h0 && !o_mapping_lock && o_input_select == 80'h0;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("state not cleared");
    c_lock: cover property (cfg_wr ##2 o_mapping_lock);
    c_mapped: cover property (o_pin_mapped != 30'h0);
    c_refuse: cover property (o_mapping_lock && i_single_session && cfg_wr && !i_wdata[RMP_LOCK_BIT]);
endmodule : rmp_remap_checker
bind rmp_remap_output_select_lock rmp_remap_checker u_chk (.i_sys_clk, .i_rst, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .i_unlock_granted, .i_single_session, .i_analog_sel, .o_pin_oe,
    .o_pin_mapped, .o_mapping_lock, .o_input_select);
`default_nettype wire

// ---- verif/rmp_remap_output_select_lock_tb.sv ----
// self-checking bench for the remap and lock block
`default_nettype none
module rmp_remap_output_select_lock_tb
    import rmp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        i_sys_clk = 1'b0;
    logic        i_rst = 1'b1;
    logic [7:0]  i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic        i_wr = 1'b0;
    logic        i_rd = 1'b0;
    logic        grant = 1'b0;
    logic        one_way = 1'b1;
    logic [17:0] lvl = 18'h0;
    logic [29:0] gp_out = 30'h0;
    logic [29:0] gp_oe = 30'h0;
    logic [29:0] ana = 30'h0;
    logic [17:0] per;
    logic [31:0] o_rdata, rd_v;
    logic [29:0] o_pin_out, o_pin_oe, o_pin_mapped;
    logic        o_mapping_lock;
    logic [79:0] o_input_select;
    int          n_mismatch = 0;
    int          total_checks = 0;
    // pin, code, peripheral index
    localparam logic [19:0] TBL [20] = '{20'h00100, 20'h00201, 20'h00304, 20'h00406, 20'h00507,
        20'h0070d, 20'h0730f, 20'h07410, 20'h07508, 20'h0770e, 20'h0f30f, 20'h0f410, 20'h0f50a,
        20'h0f60b, 20'h0f711, 20'h16102, 20'h16203, 20'h16405, 20'h16509, 20'h1670c};
    rmp_periph_model u_per (.i_level(lvl), .o_level(per));
    rmp_remap_output_select_lock dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
        .i_unlock_granted(grant), .i_single_session(one_way), .i_uart1_transmit(per[0]),
        .i_uart2_request_to_send(per[1]), .i_uart1_request_to_send(per[2]), .i_uart2_transmit(per[3]),
        .i_spi1_slave_select(per[4]), .i_spi2_slave_select(per[5]), .i_usb_bus_power_enable(per[6]),
        .i_compare_output_1(per[7]), .i_compare_output_2(per[8]), .i_compare_output_3(per[9]),
        .i_compare_output_4(per[10]), .i_compare_output_5(per[11]), .i_comparator_1_output(per[12]),
        .i_comparator_2_output(per[13]), .i_comparator_3_output(per[14]), .i_spi1_data_out(per[15]),
        .i_spi2_data_out(per[16]), .i_reference_clock_output(per[17]), .i_gpio_out(gp_out),
        .i_gpio_oe(gp_oe), .i_analog_sel(ana), .o_pin_out, .o_pin_oe, .o_pin_mapped, .o_mapping_lock,
        .o_input_select);
    initial forever #2.5 i_sys_clk = ~i_sys_clk;
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        rd_v = o_rdata;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge i_sys_clk);
        @(negedge i_sys_clk);
    endtask : settle
    task automatic do_reset();
        @(posedge i_sys_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        settle(1);
    endtask : do_reset
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        rd(8'h00);
        chk(rd_v, 32'h0);
        rd(RMP_STATUS_ADDR);
        chk(rd_v, 32'h2000_0000);
        rd(8'h7f);
        chk(rd_v, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_route();
        logic [7:0] p;
        @(posedge i_sys_clk);
        gp_out <= '1;
        gp_oe <= '1;
        for (int k = 0; k < 20; k++) begin
            p = TBL[k][19:12];
            wr(p, {28'h0, TBL[k][11:8]});
            lvl <= 18'h1 << TBL[k][4:0];
            settle(3);
            chk({o_pin_mapped[p], o_pin_oe[p], o_pin_out[p]}, 32'h7);
            @(posedge i_sys_clk);
            lvl <= ~(18'h1 << TBL[k][4:0]);
            settle(2);
            chk({31'h0, o_pin_out[p]}, 32'h0);
            rd(p);
            chk(rd_v, {28'h0, TBL[k][11:8]});
        end
        wr(8'h07, 32'h1);
        wr(8'h00, 32'h1);
        ana <= 30'h1;
        settle(3);
        chk({o_pin_mapped[7], o_pin_out[7]}, 32'h1);
        chk({31'h0, o_pin_mapped[0]}, 32'h0);
        wr(8'h40, 32'h5);
        settle(2);
        chk({28'h0, o_input_select[3:0]}, 32'h5);
        $display("test route done");
    endtask : t_route
    task automatic t_lock();
        wr(RMP_CONFIGURATION_CONTROL_REGISTER_ADDR, 32'h2000);
        settle(2);
        chk({31'h0, o_mapping_lock}, 32'h0);
        grant <= 1'b1;
        wr(RMP_CONFIGURATION_CONTROL_REGISTER_ADDR, 32'h2000);
        wr(8'h00, 32'h3);
        wr(8'h40, 32'h9);
        wr(RMP_CONFIGURATION_CONTROL_REGISTER_ADDR, 32'h0);
        settle(2);
        chk({31'h0, o_mapping_lock}, 32'h1);
        chk({28'h0, o_input_select[3:0]}, 32'h5);
        rd(RMP_CONFIGURATION_CONTROL_REGISTER_ADDR);
        chk(rd_v, 32'h2000);
        rd(8'h00);
        chk(rd_v, 32'h1);
        do_reset();
        chk({31'h0, o_mapping_lock}, 32'h0);
        rd(8'h00);
        chk(rd_v, 32'h0);
        one_way <= 1'b0;
        wr(RMP_CONFIGURATION_CONTROL_REGISTER_ADDR, 32'h2000);
        wr(8'h00, 32'h2);
        wr(RMP_CONFIGURATION_CONTROL_REGISTER_ADDR, 32'h0);
        wr(8'h01, 32'h5);
        settle(2);
        chk({31'h0, o_mapping_lock}, 32'h0);
        rd(8'h00);
        chk(rd_v, 32'h0);
        rd(8'h01);
        chk(rd_v, 32'h5);
        $display("test lock done");
    endtask : t_lock
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_mismatch++;
        tally_and_finish();
    end
    initial begin
        do_reset();
        t_reset();
        t_route();
        t_lock();
        tally_and_finish();
    end
endmodule : rmp_remap_output_select_lock_tb
`default_nettype wire
